/* File: shared/dmcs_params.svh */
`ifndef DMCS_PARAMS_SVH
`define DMCS_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DMCS_BUS_W        16
`define DMCS_ADDR_W       18
`define DMCS_RFSH_W       8
`define DMCS_ZOOM_W       4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DMCS_CORE_CLK_NS  20
`define DMCS_HALF_WORD_NS 20
`define DMCS_HALF_TICKS   ((`DMCS_HALF_WORD_NS + `DMCS_CORE_CLK_NS - 1) / `DMCS_CORE_CLK_NS)
`define DMCS_PHASE_FIRST  1'b0
`define DMCS_PHASE_LAST   1'b1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMCS_ADDR_RST     18'h00000
`define DMCS_DATA_RST     16'h0000
`define DMCS_RFSH_RST     8'h00
`define DMCS_ZCNT_ONE     5'h01
`define DMCS_ZCNT_RST     5'h00

`endif

/* File: shared/dmcs_pkg.sv */
package dmcs_pkg;

    // Gray along P1 -> P2 -> P3 -> P4, zoom periods hang off P2
    typedef enum logic [2:0] {
        DMCS_ST_P1   = 3'b000,
        DMCS_ST_P2   = 3'b001,
        DMCS_ST_P3   = 3'b011,
        DMCS_ST_P4   = 3'b010,
        DMCS_ST_ZOOM = 3'b110
    } dmcs_state_t;

    typedef enum logic [2:0] {
        DMCS_CYC_BLANK   = 3'h0,
        DMCS_CYC_DISPLAY = 3'h1,
        DMCS_CYC_ZOOM    = 3'h2,
        DMCS_CYC_RMW     = 3'h3,
        DMCS_CYC_REFRESH = 3'h4
    } dmcs_cycle_t;

    typedef enum logic [1:0] {
        DMCS_OP_REPLACE    = 2'h0,
        DMCS_OP_COMPLEMENT = 2'h1,
        DMCS_OP_CLEAR      = 2'h2,
        DMCS_OP_SET        = 2'h3
    } dmcs_draw_op_t;

endpackage : dmcs_pkg

/* File: shared/dmcs_rfsh_if.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"

interface dmcs_rfsh_if #(
    parameter int RFSH_W = `DMCS_RFSH_W
);
    logic              step;
    logic [RFSH_W-1:0] row;

    modport seq  (output step, input  row);
    modport cnt  (input  step, output row);
endinterface : dmcs_rfsh_if

/* File: hdl/dmcs_refresh.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"

module dmcs_refresh #(
    parameter int RFSH_W = `DMCS_RFSH_W
) (
    input  wire logic  core_clk,    // Core clock
    input  wire logic  rst,         // Async reset, high
    input  wire logic  ce,          // Clock enable
    dmcs_rfsh_if.cnt   rf           // Step in, row out
);

    logic [RFSH_W-1:0] row_reg;
    logic [RFSH_W-1:0] row_next;

    initial
    begin
        if (RFSH_W < 1 || RFSH_W > `DMCS_BUS_W)
            $error("dmcs_refresh: RFSH_W out of range");
    end

    // Wraps freely so every row recurs each 2**RFSH_W refresh cycles
    assign row_next = rf.step ? RFSH_W'(row_reg + 1'b1) : row_reg;
    assign rf.row   = row_reg;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            row_reg <= `DMCS_RFSH_RST;
        else if (ce)
            row_reg <= row_next;
    end

endmodule : dmcs_refresh

/* File: hdl/dmcs_seq.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"


module dmcs_seq #(
    parameter int ADDR_W = `DMCS_ADDR_W,
    parameter int ZOOM_W = `DMCS_ZOOM_W,
    parameter int RFSH_W = `DMCS_RFSH_W
) (
    input  wire logic                  core_clk,                 // Core clock
    input  wire logic                  rst,                      // Async reset, high
    input  wire logic                  ce,                       // Clock enable
    input  wire logic                  active_scan,              // Active raster time
    input  wire logic                  hsync,                    // Horizontal sync
    input  wire logic                  disp_req,                 // Scan wants a fetch
    input  wire logic [ADDR_W-1:0]     disp_addr,                // Fetch address
    input  wire logic [ZOOM_W-1:0]     zoom_factor,              // Zoom minus one
    input  wire logic                  draw_anytime,             // Draw during scan
    input  wire logic                  refresh_en,               // Refresh on sync
    input  wire logic                  draw_req,                 // Drawing pending
    input  wire logic [ADDR_W-1:0]     draw_addr,                // Drawing address
    input  wire dmcs_pkg::dmcs_draw_op_t draw_op,                // Modify operation
    input  wire logic [`DMCS_BUS_W-1:0] draw_pattern,            // Modify pattern
    input  wire logic [`DMCS_BUS_W-1:0] draw_mask,               // Bits to modify
    output logic                       draw_ack,                 // Drawing done
    output logic                       disp_ack,                 // Fetch issued
    input  wire logic [`DMCS_BUS_W-1:0] muxed_addr_data_bus_i,   // Bus in
    output logic [`DMCS_BUS_W-1:0]     muxed_addr_data_bus_o,    // Bus out
    output logic                       muxed_addr_data_bus_oe,   // Bus drive
    output logic                       upper_address_bit_lo,     // Address 16
    output logic                       upper_address_bit_hi,     // Address 17
    output logic                       ale,                      // Address strobe
    output logic                       read_data_input_strobe_n, // Read strobe
    output logic                       word_rate_clock,          // Word clock out
    output dmcs_pkg::dmcs_cycle_t      cycle_type,               // Current type
    output logic                       blank,                    // Not display
    output logic [`DMCS_BUS_W-1:0]     rmw_read_data             // Last read word
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    initial
    begin
        if (ADDR_W <= `DMCS_BUS_W || ADDR_W > `DMCS_ADDR_W)
            $error("dmcs_seq: ADDR_W out of range");
        if (ZOOM_W < 1 || ZOOM_W > `DMCS_BUS_W)
            $error("dmcs_seq: ZOOM_W out of range");
        if (RFSH_W < 1 || RFSH_W > `DMCS_BUS_W)
            $error("dmcs_seq: RFSH_W out of range");
        if (`DMCS_HALF_TICKS != 1)
            $error("dmcs_seq: half word period must be one core cycle");
    end

    localparam int ZC_W = ZOOM_W + 1;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dmcs_pkg::dmcs_state_t      state_reg;
    dmcs_pkg::dmcs_state_t      state_next;
    dmcs_pkg::dmcs_cycle_t      type_reg;
    dmcs_pkg::dmcs_cycle_t      type_next;
    logic                       phase_reg;
    logic [ADDR_W-1:0]          addr_reg;
    logic [ADDR_W-1:0]          addr_next;
    logic [ZC_W-1:0]            zcnt_reg;
    logic [ZC_W-1:0]            zcnt_next;
    logic [`DMCS_BUS_W-1:0]     rdata_reg;
    logic [`DMCS_BUS_W-1:0]     wdata_reg;
    logic [`DMCS_BUS_W-1:0]     wdata_next;
    logic                       draw_ack_reg;
    logic                       disp_ack_reg;

    dmcs_rfsh_if #(.RFSH_W(RFSH_W)) rfsh ();

    dmcs_refresh #(
        .RFSH_W (RFSH_W)
    ) u_refresh (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .rf       (rfsh.cnt)
    );

    // ----------------------------------------------------------------
    // Period timing
    // ----------------------------------------------------------------
    // A word period is two core cycles: first half and second half
    wire period_end  = (phase_reg == `DMCS_PHASE_LAST);
    wire in_p1       = (state_reg == dmcs_pkg::DMCS_ST_P1);
    wire in_p2       = (state_reg == dmcs_pkg::DMCS_ST_P2);
    wire in_p3       = (state_reg == dmcs_pkg::DMCS_ST_P3);
    wire in_p4       = (state_reg == dmcs_pkg::DMCS_ST_P4);
    wire in_zoom     = (state_reg == dmcs_pkg::DMCS_ST_ZOOM);
    wire is_rmw      = (type_reg == dmcs_pkg::DMCS_CYC_RMW);
    wire is_zoomed   = (type_reg == dmcs_pkg::DMCS_CYC_ZOOM);
    wire zoom_more   = is_zoomed && (zcnt_reg != `DMCS_ZCNT_RST);
    wire zoom_last   = (zcnt_reg == `DMCS_ZCNT_ONE);

    // Cycle ends only after whole periods, so lengths stay even
    wire cycle_end   = period_end &&
                       ((in_p2 && !is_rmw && !zoom_more) ||
                        in_p4 ||
                        (in_zoom && zoom_last));

    // Word clock high in first half, so its rising edge opens a period
    assign word_rate_clock = (phase_reg == `DMCS_PHASE_FIRST);

    // ----------------------------------------------------------------
    // Cycle choice
    // ----------------------------------------------------------------
    // Display fetches own active scan; drawing only fills idle slots
    wire draw_allowed = draw_req && (draw_anytime || !active_scan);
    wire pick_rfsh    = hsync && refresh_en;
    wire pick_disp    = !hsync && active_scan && disp_req;
    wire pick_draw    = !pick_rfsh && !pick_disp && draw_allowed;
    wire zoom_on      = (zoom_factor != '0);

    always_comb
    begin
        if (pick_rfsh)
            type_next = dmcs_pkg::DMCS_CYC_REFRESH;
        else if (pick_disp && zoom_on)
            type_next = dmcs_pkg::DMCS_CYC_ZOOM;
        else if (pick_disp)
            type_next = dmcs_pkg::DMCS_CYC_DISPLAY;
        else if (pick_draw)
            type_next = dmcs_pkg::DMCS_CYC_RMW;
        else
            type_next = dmcs_pkg::DMCS_CYC_BLANK;
    end

    // Refresh row replaces only the low lines; the rest keep scan address
    wire [ADDR_W-1:0] rfsh_addr = {disp_addr[ADDR_W-1:RFSH_W], rfsh.row};
    wire [ADDR_W-1:0] sel_addr  = pick_rfsh ? rfsh_addr :
                                  pick_disp ? disp_addr :
                                  pick_draw ? draw_addr : disp_addr;

    assign addr_next = cycle_end ? sel_addr : addr_reg;
    assign rfsh.step = ce && cycle_end && pick_rfsh;

    // Added zoom periods come in pairs
    assign zcnt_next = (cycle_end && pick_disp) ?
                       ZC_W'({zoom_factor, 1'b0}) :
                       (in_zoom && period_end) ? ZC_W'(zcnt_reg - 1'b1) :
                       zcnt_reg;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            dmcs_pkg::DMCS_ST_P1:
                if (period_end)
                    state_next = dmcs_pkg::DMCS_ST_P2;
            dmcs_pkg::DMCS_ST_P2:
                if (period_end)
                begin
                    if (is_rmw)
                        state_next = dmcs_pkg::DMCS_ST_P3;
                    else if (zoom_more)
                        state_next = dmcs_pkg::DMCS_ST_ZOOM;
                    else
                        state_next = dmcs_pkg::DMCS_ST_P1;
                end
            dmcs_pkg::DMCS_ST_P3:
                if (period_end)
                    state_next = dmcs_pkg::DMCS_ST_P4;
            dmcs_pkg::DMCS_ST_P4:
                if (period_end)
                    state_next = dmcs_pkg::DMCS_ST_P1;
            dmcs_pkg::DMCS_ST_ZOOM:
                if (period_end && zoom_last)
                    state_next = dmcs_pkg::DMCS_ST_P1;
            default:
                state_next = dmcs_pkg::DMCS_ST_P1;
        endcase
    end

    // ----------------------------------------------------------------
    // Modify unit
    // ----------------------------------------------------------------
    logic [`DMCS_BUS_W-1:0] op_bits;

    always_comb
    begin
        case (draw_op)
            dmcs_pkg::DMCS_OP_REPLACE:    op_bits = draw_pattern;
            dmcs_pkg::DMCS_OP_COMPLEMENT: op_bits = ~muxed_addr_data_bus_i;
            dmcs_pkg::DMCS_OP_CLEAR:      op_bits = '0;
            dmcs_pkg::DMCS_OP_SET:        op_bits = '1;
            default:                      op_bits = draw_pattern;
        endcase
    end

    // Sampled at the end of the read strobe, then merged under the mask
    wire sample_now = in_p3 && period_end && is_rmw;
    assign wdata_next = sample_now ?
                        ((muxed_addr_data_bus_i & ~draw_mask) | (op_bits & draw_mask)) :
                        wdata_reg;

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    // High only in the first half of period one and through zoom padding;
    // the strobe falls mid period one so outside logic keys on the edge
    assign ale = (in_p1 && phase_reg == `DMCS_PHASE_FIRST) ||
                 in_zoom;

    // No type-specific change before mid period two
    assign read_data_input_strobe_n = !(is_rmw &&
                                        ((in_p2 && period_end) || in_p3));

    // Address for period one, modified data in period four, else float
    assign muxed_addr_data_bus_oe = in_p1 || (in_p4 && is_rmw);
    assign muxed_addr_data_bus_o  = in_p1 ? addr_reg[`DMCS_BUS_W-1:0] :
                                    in_p4 ? wdata_reg : `DMCS_DATA_RST;

    // Held from the address register, which only moves at cycle start
    assign upper_address_bit_lo = addr_reg[`DMCS_BUS_W];
    assign upper_address_bit_hi = (ADDR_W > `DMCS_BUS_W + 1) ?
                                  addr_reg[ADDR_W-1] : 1'b0;

    assign cycle_type    = type_reg;
    assign blank         = !(type_reg == dmcs_pkg::DMCS_CYC_DISPLAY ||
                             type_reg == dmcs_pkg::DMCS_CYC_ZOOM);
    assign rmw_read_data = rdata_reg;
    assign draw_ack      = draw_ack_reg;
    assign disp_ack      = disp_ack_reg;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_reg <= `DMCS_PHASE_FIRST;
            state_reg <= dmcs_pkg::DMCS_ST_P1;
            type_reg  <= dmcs_pkg::DMCS_CYC_BLANK;
        end
        else if (ce)
        begin
            phase_reg <= ~phase_reg;
            state_reg <= state_next;
            if (cycle_end)
                type_reg <= type_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_reg  <= ADDR_W'(`DMCS_ADDR_RST);
            zcnt_reg  <= `DMCS_ZCNT_RST;
            wdata_reg <= `DMCS_DATA_RST;
        end
        else if (ce)
        begin
            addr_reg  <= addr_next;
            zcnt_reg  <= zcnt_next;
            wdata_reg <= wdata_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= `DMCS_DATA_RST;
        else if (ce && sample_now)
            rdata_reg <= muxed_addr_data_bus_i;
    end

    // One-cycle pulses so requesters can advance their queues
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            draw_ack_reg <= 1'b0;
            disp_ack_reg <= 1'b0;
        end
        else if (ce)
        begin
            draw_ack_reg <= in_p4 && period_end && is_rmw;
            disp_ack_reg <= cycle_end && pick_disp;
        end
        else
        begin
            draw_ack_reg <= 1'b0;
            disp_ack_reg <= 1'b0;
        end
    end

endmodule : dmcs_seq

/* File: verif/dmcs_seq_props.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"

module dmcs_seq_props (
    input wire logic                   core_clk,                 // Clock
    input wire logic                   rst,                      // Reset
    input wire logic [`DMCS_BUS_W-1:0] muxed_addr_data_bus_o,    // Bus out
    input wire logic                   muxed_addr_data_bus_oe,   // Bus drive
    input wire logic                   upper_address_bit_lo,     // Address 16
    input wire logic                   upper_address_bit_hi,     // Address 17
    input wire logic                   ale,                      // Latch strobe
    input wire logic                   read_data_input_strobe_n, // Read strobe
    input wire logic                   word_rate_clock,          // Word clock
    input wire dmcs_pkg::dmcs_cycle_t  cycle_type,               // Cycle type
    input wire logic                   blank,                    // Blanked
    input wire logic                   draw_ack                  // Drawing done
);
    logic       start;
    logic       is_rfsh;
    logic [7:0] len_cnt;
    logic [7:0] row_last;
    logic       row_seen;

    assign start   = ale && muxed_addr_data_bus_oe;
    assign is_rfsh = cycle_type == dmcs_pkg::DMCS_CYC_REFRESH;

    // --------------------------------------------------------
    // Cycle length and refresh row trackers
    // --------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            len_cnt  <= 8'h00; // Zero until the first cycle start is seen
            row_last <= 8'h00;
            row_seen <= 1'b0;
        end
        else
        begin
            len_cnt <= start ? 8'h01 : len_cnt + 8'h01;
            if (start && is_rfsh)
            begin
                row_last <= muxed_addr_data_bus_o[7:0];
                row_seen <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_even_len: assert property (start && len_cnt != 8'h00 |->
        !len_cnt[0] && len_cnt >= 8'h04 && len_cnt <= 8'h40)
        else $error("cycle length odd or out of range");
    a_word_phase: assert property (start |-> word_rate_clock ##1 !word_rate_clock)
        else $error("word clock not aligned to cycle start");
    a_ale_low: assert property (start |=> !ale [*3])
        else $error("latch strobe not low through period two");
    a_bus_float: assert property (start |=> muxed_addr_data_bus_oe ##1 !muxed_addr_data_bus_oe)
        else $error("bus not held for period one then floated");
    a_upper_hold: assert property (!start |-> $stable({upper_address_bit_hi, upper_address_bit_lo}))
        else $error("upper address moved inside a cycle");
    a_strobe_idle: assert property (start |-> read_data_input_strobe_n [*3])
        else $error("read strobe reveals type too early");
    a_rmw_read: assert property ($fell(read_data_input_strobe_n) |->
        (!read_data_input_strobe_n && cycle_type == dmcs_pkg::DMCS_CYC_RMW) [*3]
        ##1 (read_data_input_strobe_n && muxed_addr_data_bus_oe))
        else $error("read strobe window or write back wrong");
    a_draw_done: assert property ($fell(read_data_input_strobe_n) |-> ##5 draw_ack)
        else $error("drawing done pulse misplaced");
    a_blank_type: assert property (blank == !(cycle_type == dmcs_pkg::DMCS_CYC_DISPLAY
        || cycle_type == dmcs_pkg::DMCS_CYC_ZOOM))
        else $error("blank disagrees with cycle type");
    a_row_step: assert property (start && is_rfsh && row_seen |->
        muxed_addr_data_bus_o[7:0] == row_last + 8'h01)
        else $error("refresh row did not step by one");
endmodule : dmcs_seq_props

bind dmcs_seq dmcs_seq_props props_u (.core_clk, .rst, .muxed_addr_data_bus_o,
    .muxed_addr_data_bus_oe, .upper_address_bit_lo, .upper_address_bit_hi, .ale,
    .read_data_input_strobe_n, .word_rate_clock, .cycle_type, .blank, .draw_ack);

/* File: verif/dmcs_mem_model.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"

module dmcs_mem_model (
    input  wire logic                   core_clk, // Shared clock
    input  wire logic                   ale,      // Latch strobe
    input  wire logic                   oe,       // Device drives bus
    input  wire logic [`DMCS_BUS_W-1:0] bus_o,    // Device bus value
    input  wire logic                   rd_n,     // Read strobe
    output logic      [`DMCS_BUS_W-1:0] bus_i     // Memory bus value
);
    logic [15:0] mem [0:15];
    logic [3:0]  row_q;
    logic        ale_d;
    logic        wr_arm;

    // Word settled well before period two ends; inverted while device drives
    assign bus_i = oe ? ~mem[row_q] : mem[row_q];

    always @(posedge core_clk)
    begin
        ale_d <= ale;
        if (ale_d && !ale)
            row_q <= bus_o[3:0];
        // Refresh never lowers the read strobe, so no column access follows
        if (ale)
            wr_arm <= 1'b0;
        else if (!rd_n)
            wr_arm <= 1'b1;
        if (wr_arm && oe && !ale)
            mem[row_q] <= bus_o;
    end
endmodule : dmcs_mem_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "dmcs_params.svh"

module testbench;
    logic                   core_clk, rst, ce, active_scan, hsync, disp_req;
    logic                   draw_anytime, refresh_en, draw_req;
    logic [17:0]            disp_addr, draw_addr;
    logic [3:0]             zoom_factor;
    dmcs_pkg::dmcs_draw_op_t draw_op;
    logic [15:0]            draw_pattern, draw_mask, bus_i, bus_o, rmw_read_data;
    logic                   draw_ack, disp_ack, oe, lo, hi, ale, read_data_input_strobe_n_n, wrc, blank;
    dmcs_pkg::dmcs_cycle_t  cycle_type;
    int                     bad_count = 0;
    int                     n_checks = 0;

    dmcs_seq dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .active_scan(active_scan),
        .hsync(hsync), .disp_req(disp_req), .disp_addr(disp_addr),
        .zoom_factor(zoom_factor), .draw_anytime(draw_anytime), .refresh_en(refresh_en),
        .draw_req(draw_req), .draw_addr(draw_addr), .draw_op(draw_op),
        .draw_pattern(draw_pattern), .draw_mask(draw_mask), .draw_ack(draw_ack),
        .disp_ack(disp_ack), .muxed_addr_data_bus_i(bus_i), .muxed_addr_data_bus_o(bus_o),
        .muxed_addr_data_bus_oe(oe), .upper_address_bit_lo(lo), .upper_address_bit_hi(hi),
        .ale(ale), .read_data_input_strobe_n(read_data_input_strobe_n_n), .word_rate_clock(wrc),
        .cycle_type(cycle_type), .blank(blank), .rmw_read_data(rmw_read_data));

    dmcs_mem_model mem_u (.core_clk(core_clk), .ale(ale), .oe(oe), .bus_o(bus_o),
        .rd_n(read_data_input_strobe_n_n), .bus_i(bus_i));

    // --------------------------------------------------------
    // Common tasks
    // --------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task tick;
        @(posedge core_clk);
        #1;
    endtask : tick

    // Sampled at the falling edge, away from the launch edge
    task wait_start(input dmcs_pkg::dmcs_cycle_t t);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (!(ale === 1'b1 && oe === 1'b1 && cycle_type === t) && n < 300);
        chk(n < 300, 1);
    endtask : wait_start

    task count_rest(input int len, input int hi_n);
        int n;
        int h;
        n = 1;
        h = 1;
        @(negedge core_clk);
        while (!(ale === 1'b1 && oe === 1'b1) && n < 100)
        begin
            n++;
            h += (ale === 1'b1);
            @(negedge core_clk);
        end
        chk(n, len);
        chk(h, hi_n);
    endtask : count_rest

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task s_display;
        int zf [3] = '{0, 1, 15};
        foreach (zf[i])
        begin
            tick;
            {active_scan, disp_req, hsync, draw_req} = 4'b1100;
            disp_addr = 18'h2A5C3 + 18'(i);
            zoom_factor = 4'(zf[i]);
            wait_start(zf[i] == 0 ? dmcs_pkg::DMCS_CYC_DISPLAY : dmcs_pkg::DMCS_CYC_ZOOM);
            chk({hi, lo, bus_o}, 18'h2A5C3 + 18'(i));
            chk(disp_ack, 1);
            chk(blank, 0);
            count_rest(4 + 4 * zf[i], 1 + 4 * zf[i]);
        end
    endtask : s_display

    task s_rmw;
        logic [15:0] bits;
        logic [15:0] rd;
        for (int k = 0; k < 4; k++)
        begin
            tick;
            rd = 16'hA5C3 ^ 16'(k);
            mem_u.mem[5] = rd;
            {active_scan, disp_req, draw_anytime, draw_req} = 4'b1011;
            draw_addr = 18'h30005;
            draw_op = dmcs_pkg::dmcs_draw_op_t'(k);
            draw_pattern = 16'h0FF0;
            draw_mask = 16'h3C3C;
            wait_start(dmcs_pkg::DMCS_CYC_RMW);
            chk({hi, lo, bus_o}, 18'h30005);
            chk(disp_ack, 0);
            tick;
            disp_req = 1'b1;
            count_rest(8, 1);
            chk(draw_ack, 1);
            chk(rmw_read_data, rd);
            bits = k == 0 ? 16'h0FF0 : k == 1 ? ~rd : k == 2 ? 16'h0000 : 16'hFFFF;
            chk(mem_u.mem[5], (rd & ~16'h3C3C) | (bits & 16'h3C3C));
            tick;
            draw_req = 1'b0;
        end
    endtask : s_rmw

    task s_retrace_only;
        int n;
        tick;
        {active_scan, disp_req, draw_anytime, draw_req} = 4'b1001;
        wait_start(dmcs_pkg::DMCS_CYC_BLANK);
        n = 0;
        repeat (40)
        begin
            @(negedge core_clk);
            n += (cycle_type === dmcs_pkg::DMCS_CYC_RMW);
        end
        chk(n, 0);
        tick;
        active_scan = 1'b0;
        wait_start(dmcs_pkg::DMCS_CYC_RMW);
        tick;
        {active_scan, disp_req} = 2'b11;
        count_rest(8, 1);
        chk(draw_ack, 1);
        tick;
        draw_req = 1'b0;
    endtask : s_retrace_only

    task s_refresh;
        logic [7:0] r1;
        int n;
        tick;
        {active_scan, disp_req, hsync, refresh_en} = 4'b0111;
        wait_start(dmcs_pkg::DMCS_CYC_REFRESH);
        r1 = bus_o[7:0] + 8'h01;
        chk(blank, 1);
        count_rest(4, 1);
        chk(cycle_type, dmcs_pkg::DMCS_CYC_REFRESH);
        chk(bus_o[7:0], r1);
        tick;
        {active_scan, refresh_en} = 2'b10;
        // Let the refresh cycle under way run out first
        wait_start(dmcs_pkg::DMCS_CYC_BLANK);
        n = 0;
        repeat (30)
        begin
            @(negedge core_clk);
            n += (cycle_type === dmcs_pkg::DMCS_CYC_REFRESH);
            n += (cycle_type === dmcs_pkg::DMCS_CYC_DISPLAY);
        end
        chk(n, 0);
        tick;
        hsync = 1'b0;
    endtask : s_refresh

    // --------------------------------------------------------
    // Run control
    // --------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        #200000;
        bad_count++;
        end_sim;
    end

    initial
    begin
        {rst, ce, active_scan, hsync, disp_req, draw_anytime, refresh_en, draw_req} = 8'hC0;
        {disp_addr, draw_addr, zoom_factor} = '0;
        {draw_pattern, draw_mask} = '0;
        draw_op = dmcs_pkg::DMCS_OP_REPLACE;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        s_display;
        s_rmw;
        s_retrace_only;
        s_refresh;
        end_sim;
    end
endmodule : testbench
